// [rtl/serial_tx_defines.svh]
// Purpose : constants for the transmit FIFO empty-flag block
// Assumes : 20 MHz system clock, 16-byte transmit FIFO
// Notes   : offsets of fields and trigger encodings live here only
//
// Notes on behaviour
// R01: flag rises once a byte leaves and count is at or below trigger.
// R02: transmission lowering count to trigger level or below sets the flag.
// R03: flag at 0 means the FIFO holds more bytes than the trigger level; here a 0 outlasts a flush or a raised trigger level.
// R04: software clears by reading 1, writing 0, with data beyond trigger.
// R05: a DMA write lifting count above trigger clears the flag directly.
// R06: reset sets the flag to 1.
// R07: FIFO holds 16 bytes; sixteen minus trigger may follow a set flag.
// R08: writes into a full FIFO are dropped, contents and count unchanged.
// R09: transmit byte count is reported in the upper byte of the count word.
// R10: a two-bit select picks the trigger level compared with the count.
`ifndef SERIAL_TX_DEFINES_SVH
`define SERIAL_TX_DEFINES_SVH

// ---------------------------------------------------------------------
// fifo geometry
// ---------------------------------------------------------------------
`define TXF_DEPTH      16
`define TXF_WIDTH      8
`define TXF_CNT_W      5

// ---------------------------------------------------------------------
// trigger select encodings and the levels they pick
// ---------------------------------------------------------------------
`define TRIG_SEL_A     2'h0
`define TRIG_SEL_B     2'h1
`define TRIG_SEL_C     2'h2
`define TRIG_SEL_D     2'h3
`define TRIG_LVL_A     5'h08
`define TRIG_LVL_B     5'h04
`define TRIG_LVL_C     5'h02
`define TRIG_LVL_D     5'h00

// ---------------------------------------------------------------------
// count word layout and reset values
// ---------------------------------------------------------------------
`define CNT_WORD_W     16
`define CNT_TX_MSB     15
`define CNT_TX_LSB     8
`define CNT_LO_FILL    8'h00
`define CNT_HI_PAD     3'h0
`define FLAG_RST_VAL   1'b1

`endif

// [rtl/serial_tx_pkg.sv]
// Purpose : shared types of the transmit FIFO empty-flag block
// Assumes : constants come from serial_tx_defines.svh
// Notes   : types only, no logic
`include "serial_tx_defines.svh"

package serial_tx_pkg;

    // a byte offered by one writer
    typedef struct packed {
        logic                    valid;
        logic [`TXF_WIDTH-1:0]   data;
    } byte_req_type;

    // state of the flag logic
    typedef struct packed {
        logic                    flag;
        logic                    armed;
        logic                    clear_req;
    } flag_state_type;

endpackage

// [rtl/tx_byte_fifo.sv]
// Purpose : synchronous FIFO with valid/ready on both sides
// Assumes : single clock, asynchronous active-high reset
// Notes   : in_ready_o low when full; pushes then are refused, not stored
`timescale 1ns/1ps

module tx_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          flush_i,
    input  wire logic                          in_valid_i,
    input  wire logic [WIDTH-1:0]              in_data_i,
    output logic                               in_ready_o,
    output logic                               out_valid_o,
    output logic [WIDTH-1:0]                   out_data_o,
    input  wire logic                          out_ready_i,
    output logic [$clog2(DEPTH+1)-1:0]         count_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [PW-1:0]   wr_ptr;
        logic [PW-1:0]   rd_ptr;
        logic [CW-1:0]   count;
    } fifo_state_type;

    fifo_state_type      st_q;
    fifo_state_type      st_d;
    logic [WIDTH-1:0]    mem [DEPTH];
    logic                push;
    logic                pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        if (p == PW'(DEPTH-1)) begin
            return '0;
        end
        return p + PW'(1);
    endfunction

    // -----------------------------------------------------------------
    // handshakes
    // -----------------------------------------------------------------
    assign in_ready_o  = (st_q.count != CW'(DEPTH)) && !flush_i;
    assign out_valid_o = (st_q.count != '0) && !flush_i;
    assign out_data_o  = mem[st_q.rd_ptr];
    assign count_o     = st_q.count;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // -----------------------------------------------------------------
    // pointers and count
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (flush_i) begin
            st_d = '0;
        end else begin
            if (push) begin
                st_d.wr_ptr = bump(st_q.wr_ptr);
            end
            if (pop) begin
                st_d.rd_ptr = bump(st_q.rd_ptr);
            end
            if (push && !pop) begin
                st_d.count = st_q.count + CW'(1);
            end else if (pop && !push) begin
                st_d.count = st_q.count - CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // storage needs no reset; unread words are never presented
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[st_q.wr_ptr] <= in_data_i;
        end
    end

endmodule

// [rtl/tx_empty_flag.sv]
// Purpose : transmit FIFO with its empty flag against a trigger level
// Assumes : all inputs synchronous to CLK_SYS_I; strobes last one cycle
// Notes   : CPU and DMA share the FIFO write port, CPU has priority
//           a DMA byte offered beside a CPU byte is dropped
//           a flush empties the FIFO and leaves the flag alone
//           writing 1 to the flag is ignored; only a read of 1 arms
`timescale 1ns/1ps
`include "serial_tx_defines.svh"

module tx_empty_flag #(
    parameter int DEPTH = `TXF_DEPTH,
    parameter int WIDTH = `TXF_WIDTH
) (
    input  wire logic                          CLK_SYS_I,
    input  wire logic                          RESET_I,
    input  wire serial_tx_pkg::byte_req_type   CPU_WR_I,
    input  wire serial_tx_pkg::byte_req_type   DMA_WR_I,
    output logic                               WR_READY_O,
    input  wire logic                          TX_FIFO_CLEAR_I,
    input  wire logic [1:0]                    TX_TRIGGER_SEL_I,
    input  wire logic                          FLAG_RD_I,
    input  wire logic                          FLAG_WR_I,
    input  wire logic                          FLAG_WDATA_I,
    output logic                               TX_FIFO_EMPTY_FLAG_O,
    output logic [`CNT_WORD_W-1:0]             FIFO_COUNT_O,
    output logic                               SHIFT_VALID_O,
    output logic [WIDTH-1:0]                   SHIFT_DATA_O,
    input  wire logic                          SHIFT_READY_I
);
    import serial_tx_pkg::*;

    localparam int CW = $clog2(DEPTH+1);

    // -----------------------------------------------------------------
    // internal signals
    // -----------------------------------------------------------------
    flag_state_type      st_q;
    flag_state_type      st_d;
    logic                fifo_in_valid;
    logic [WIDTH-1:0]    fifo_in_data;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [CW-1:0]       count_q;
    logic [CW-1:0]       count_nx;
    logic [CW-1:0]       trig_lvl;
    logic                accepted;
    logic                cpu_taken;
    logic                dma_taken;
    logic                popped;
    logic                set_ev;
    logic                above_trig;
    logic                cpu_clear;
    logic                dma_clear;
    logic                arm_ev;
    logic                write0_ev;

    // -----------------------------------------------------------------
    // write arbitration
    // -----------------------------------------------------------------
    // the CPU wins a shared cycle; WR_READY_O is one signal for both
    // writers, so a DMA byte offered beside a CPU byte is dropped
    // without warning and the DMA side must not overlap CPU writes
    always_comb begin
        fifo_in_valid = 1'b0;
        fifo_in_data  = DMA_WR_I.data;
        cpu_taken     = 1'b0;
        dma_taken     = 1'b0;
        if (CPU_WR_I.valid) begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = CPU_WR_I.data;
            cpu_taken     = fifo_in_ready;
        end else if (DMA_WR_I.valid) begin
            fifo_in_valid = 1'b1;
            dma_taken     = fifo_in_ready;
        end
    end

    assign WR_READY_O = fifo_in_ready;
    // a write with the FIFO full is refused and the byte is lost
    assign accepted   = cpu_taken || dma_taken;            // R08
    assign popped     = fifo_out_valid && SHIFT_READY_I;

    // -----------------------------------------------------------------
    // byte store feeding the shift register
    // -----------------------------------------------------------------
    tx_byte_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (CLK_SYS_I),
        .rst_i       (RESET_I),
        .flush_i     (TX_FIFO_CLEAR_I),
        .in_valid_i  (fifo_in_valid),
        .in_data_i   (fifo_in_data),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (SHIFT_DATA_O),
        .out_ready_i (SHIFT_READY_I),
        .count_o     (count_q)
    );                                                     // R07

    // -----------------------------------------------------------------
    // shift side
    // -----------------------------------------------------------------
    // the head byte stands on SHIFT_DATA_O until the shift side takes it
    assign SHIFT_VALID_O = fifo_out_valid;

    // -----------------------------------------------------------------
    // count word
    // -----------------------------------------------------------------
    // low byte belongs to the receive side and reads zero here
    always_comb begin
        FIFO_COUNT_O = '0;
        FIFO_COUNT_O[`CNT_TX_MSB:`CNT_TX_LSB] = {`CNT_HI_PAD, count_q}; // R09
        FIFO_COUNT_O[`CNT_TX_LSB-1:0]         = `CNT_LO_FILL;
    end

    // -----------------------------------------------------------------
    // trigger level
    // -----------------------------------------------------------------
    // select 3 gives level 0: the flag then waits for a dry FIFO
    always_comb begin
        case (TX_TRIGGER_SEL_I)                            // R10
            `TRIG_SEL_A: trig_lvl = `TRIG_LVL_A;
            `TRIG_SEL_B: trig_lvl = `TRIG_LVL_B;
            `TRIG_SEL_C: trig_lvl = `TRIG_LVL_C;
            `TRIG_SEL_D: trig_lvl = `TRIG_LVL_D;
            default:     trig_lvl = `TRIG_LVL_A;
        endcase
    end

    // -----------------------------------------------------------------
    // count after this cycle's push and pop
    // -----------------------------------------------------------------
    // decisions use the count as it stands after this edge, so a push
    // and a pop in one cycle cancel, yet the pop still sets the flag if that count is at or below the level
    always_comb begin
        count_nx = count_q;
        if (TX_FIFO_CLEAR_I) begin
            count_nx = '0;
        end else if (accepted && !popped) begin
            count_nx = count_q + CW'(1);
        end else if (popped && !accepted) begin
            count_nx = count_q - CW'(1);
        end
    end

    assign above_trig = count_nx > trig_lvl;

    // -----------------------------------------------------------------
    // flag events
    // -----------------------------------------------------------------
    // only a byte moving to the shift register sets the flag; a flush
    // leaves it alone, so a 0 may outlast a flush until the next byte
    // is sent
    always_comb begin
        set_ev    = 1'b0;
        arm_ev    = 1'b0;
        write0_ev = 1'b0;
        cpu_clear = 1'b0;
        dma_clear = 1'b0;
        if (popped && !above_trig) begin
            set_ev = 1'b1;                                 // R01 R02
        end
        // reading a 1 arms the clear; writing 1 never sets the flag
        if (FLAG_RD_I && st_q.flag) begin
            arm_ev = 1'b1;                                 // R04
        end
        if (FLAG_WR_I && !FLAG_WDATA_I && st_q.armed) begin
            write0_ev = 1'b1;
        end
        // the armed write of 0 waits until the count passes the
        // trigger level, so the clear cannot land before the data
        if ((st_q.clear_req || write0_ev) && above_trig) begin
            cpu_clear = 1'b1;                              // R04
        end
        if (dma_taken && above_trig) begin
            dma_clear = 1'b1;                              // R05
        end
    end

    // -----------------------------------------------------------------
    // flag state
    // -----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (arm_ev) begin
            st_d.armed = 1'b1;
        end
        // a write in the cycle of the arming read sees the old arm state
        if (write0_ev) begin
            st_d.armed     = 1'b0;
            st_d.clear_req = 1'b1;
        end
        // arming and the request fall with the flag, so every CPU clear
        // needs a fresh read of 1 first
        if (set_ev) begin
            // a set in the same cycle as a clear wins
            st_d.flag      = 1'b1;                         // R02
            st_d.clear_req = 1'b0;
        end else if (cpu_clear || dma_clear) begin
            st_d.flag      = 1'b0;                         // R03
            st_d.armed     = 1'b0;
            st_d.clear_req = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            st_q <= '{flag: `FLAG_RST_VAL,                 // R06
                      armed: 1'b0,
                      clear_req: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // -----------------------------------------------------------------
    // flag output
    // -----------------------------------------------------------------
    assign TX_FIFO_EMPTY_FLAG_O = st_q.flag;

endmodule

// [test/tx_empty_flag_sva.sv]
// Purpose : port assertions for the tx empty-flag block
// Assumes : one clock domain, async active-high reset
// Notes   : levels 8/4/2/0 follow the select encoding
`timescale 1ns/1ps
`include "serial_tx_defines.svh"

module tx_empty_flag_sva (
    input  wire logic                        CLK_SYS_I,
    input  wire logic                        RESET_I,
    input  wire serial_tx_pkg::byte_req_type CPU_WR_I,
    input  wire serial_tx_pkg::byte_req_type DMA_WR_I,
    input  wire logic                        WR_READY_O,
    input  wire logic                        TX_FIFO_CLEAR_I,
    input  wire logic [1:0]                  TX_TRIGGER_SEL_I,
    input  wire logic                        TX_FIFO_EMPTY_FLAG_O,
    input  wire logic [`CNT_WORD_W-1:0]      FIFO_COUNT_O,
    input  wire logic                        SHIFT_VALID_O,
    input  wire logic                        SHIFT_READY_I
);
    import serial_tx_pkg::*;
    logic [7:0] cnt;
    logic [7:0] lvl;
    logic       pop;
    logic       push;
    logic       dma_acc;
    assign cnt = FIFO_COUNT_O[15:8];
    assign lvl = (TX_TRIGGER_SEL_I == 2'h3) ? 8'h00
                                             : 8'h08 >> TX_TRIGGER_SEL_I;
    assign pop = SHIFT_VALID_O && SHIFT_READY_I;
    assign push = (CPU_WR_I.valid || DMA_WR_I.valid) && WR_READY_O;
    assign dma_acc = DMA_WR_I.valid && !CPU_WR_I.valid && WR_READY_O;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    // a dma byte that leaves the count above the level
    sequence s_dma_over;
        dma_acc && (cnt + {7'h00, !pop}) > lvl;
    endsequence
    AST_RST_FLAG: assert property ($past(RESET_I) |->
        TX_FIFO_EMPTY_FLAG_O && cnt == 8'h00) else $error("reset state");
    AST_SET_LOW: assert property (pop |=>
        cnt > $past(lvl) || TX_FIFO_EMPTY_FLAG_O) else $error("no set");
    AST_RISE_SRC: assert property ($rose(TX_FIFO_EMPTY_FLAG_O) |->
        $past(pop) && cnt <= $past(lvl)) else $error("bad rise");
    AST_FALL_ABOVE: assert property ($fell(TX_FIFO_EMPTY_FLAG_O) |->
        cnt > $past(lvl)) else $error("bad fall");
    AST_DMA_CLR: assert property (s_dma_over |=>
        !TX_FIFO_EMPTY_FLAG_O) else $error("no dma clear");
    AST_FULL_RDY: assert property (cnt == 8'h10 |->
        !WR_READY_O) else $error("ready when full");
    AST_FULL_HOLD: assert property (cnt == 8'h10 && !pop &&
        !TX_FIFO_CLEAR_I |=> $stable(FIFO_COUNT_O)) else $error("full moved");
    AST_PUSH_CNT: assert property (push && !pop && !TX_FIFO_CLEAR_I
        |=> cnt == $past(cnt) + 8'h01) else $error("push count");
    AST_CNT_FMT: assert property (FIFO_COUNT_O[7:0] == 8'h00 &&
        cnt <= 8'h10) else $error("count word");
endmodule

bind tx_empty_flag tx_empty_flag_sva i_sva (.CLK_SYS_I, .RESET_I,
    .CPU_WR_I, .DMA_WR_I, .WR_READY_O, .TX_FIFO_CLEAR_I, .TX_TRIGGER_SEL_I,
    .TX_FIFO_EMPTY_FLAG_O, .FIFO_COUNT_O, .SHIFT_VALID_O, .SHIFT_READY_I);

// [test/tx_shift_model.sv]
// Purpose : shift-register side taking head bytes
// Assumes : stall_i changes at the falling edge
// Notes   : ready is registered, so a stall lands one edge late
`timescale 1ns/1ps

module tx_shift_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       stall_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    output logic            ready_o
);
    logic [7:0] seen [0:63];
    int         n_taken;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            n_taken <= 0;
        end else begin
            if (valid_i && ready_o) begin
                seen[n_taken % 64] <= data_i;
                n_taken <= n_taken + 1;
            end
            ready_o <= !stall_i;
        end
    end
endmodule

// [test/test_tx_empty_flag.sv]
// Purpose : scenarios for the tx empty-flag block
// Assumes : inputs change at the falling edge, 50 ns clock
// Notes   : the sink stalls while the FIFO is being filled
`timescale 1ns/1ps

module test_tx_empty_flag;
    import serial_tx_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    byte_req_type cpu = '0;
    byte_req_type dma = '0;
    logic         clr = 1'b0;
    logic [1:0]   sel = 2'h0;
    logic         rd = 1'b0;
    logic         wr = 1'b0;
    logic         wdat = 1'b1;
    logic         stall = 1'b1;
    logic         rdy, flag, sv, sr;
    logic [15:0]  cnt;
    logic [7:0]   sd;
    int           fails = 0;
    int           n_compared = 0;
    always #25 clk = ~clk;
    tx_empty_flag i_dut (.CLK_SYS_I(clk), .RESET_I(rst), .CPU_WR_I(cpu),
        .DMA_WR_I(dma), .WR_READY_O(rdy), .TX_FIFO_CLEAR_I(clr),
        .TX_TRIGGER_SEL_I(sel), .FLAG_RD_I(rd), .FLAG_WR_I(wr),
        .FLAG_WDATA_I(wdat), .TX_FIFO_EMPTY_FLAG_O(flag),
        .FIFO_COUNT_O(cnt), .SHIFT_VALID_O(sv), .SHIFT_DATA_O(sd),
        .SHIFT_READY_I(sr));
    tx_shift_model i_sink (.clk_i(clk), .rst_i(rst), .stall_i(stall),
        .valid_i(sv), .data_i(sd), .ready_o(sr));
    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(bit use_dma, logic [7:0] d);
        @(negedge clk);
        if (use_dma) dma <= '{1'b1, d};
        else cpu <= '{1'b1, d};
        @(negedge clk);
        cpu.valid <= 1'b0;
        dma.valid <= 1'b0;
    endtask
    task automatic sw_flag(logic do_rd, logic w);
        @(negedge clk);
        rd <= do_rd;
        wr <= !do_rd;
        wdat <= w;
        @(negedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wait_cnt(logic [7:0] n);
        int k;
        for (k = 0; k < 200 && cnt[15:8] !== n; k++) @(negedge clk);
        if (k == 200) begin
            fails++;
            close_out();
        end
    endtask
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_reset;
        chk("flag", 16'h1, {15'h0, flag});
        chk("count", 16'h0, cnt);
        sw_flag(1'b0, 1'b0);
        for (int k = 0; k < 9; k++) put(1'b0, 8'h20);
        chk("flag", 16'h1, {15'h0, flag});
        @(negedge clk);
        cpu <= '{1'b1, 8'h30};
        dma <= '{1'b1, 8'h31};
        @(negedge clk);
        cpu.valid <= 1'b0;
        dma.valid <= 1'b0;
        @(negedge clk) clr <= 1'b1;
        chk("count", 16'h0A00, cnt);
        chk("flag", 16'h1, {15'h0, flag});
        @(negedge clk) clr <= 1'b0;
        chk("count", 16'h0, cnt);
    endtask
    task automatic t_sw_clear;
        int base;
        logic [7:0] got_b;
        sel <= 2'h1;
        sw_flag(1'b1, 1'b1);
        sw_flag(1'b0, 1'b0);
        for (int k = 1; k <= 17; k++) begin
            put(1'b0, 8'(8'h40 + k));
            chk("flag", {15'h0, k <= 4}, {15'h0, flag});
        end
        chk("count", 16'h1000, cnt);
        chk("ready", 16'h0, {15'h0, rdy});
        sw_flag(1'b0, 1'b1);
        chk("flag", 16'h0, {15'h0, flag});
        base = i_sink.n_taken;
        stall <= 1'b0;
        wait_cnt(8'h05);
        chk("flag", 16'h0, {15'h0, flag});
        wait_cnt(8'h04);
        chk("flag", 16'h1, {15'h0, flag});
        wait_cnt(8'h00);
        for (int k = 0; k < 16; k++) begin
            got_b = i_sink.seen[(base + k) % 64];
            chk("byte", 16'(8'h41 + k), {8'h00, got_b});
        end
        stall <= 1'b1;
    endtask
    task automatic t_dma_levels;
        logic [7:0] lv;
        for (int s = 0; s < 4; s++) begin
            sel <= 2'(s);
            lv = (s == 3) ? 8'h00 : 8'h08 >> s;
            for (int k = 1; k <= lv + 1; k++) begin
                put(1'b1, 8'(k));
                chk("flag", {15'h0, k <= lv}, {15'h0, flag});
            end
            stall <= 1'b0;
            wait_cnt(8'h00);
            chk("flag", 16'h1, {15'h0, flag});
            stall <= 1'b1;
        end
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_sw_clear();
        t_dma_levels();
        close_out();
    end
endmodule
